// >>> design/epc_ctrl.v
// Purpose: host-side controller driving a 64K x 8 programmable read-only memory
// Assumes: external level shifters turn vpp_on and sig_hv_on into high voltages
// Notes:   one command at a time; data_lines_oe_n low means we drive the bus
// Function
// [R1] device outputs addressed byte when chip select and gate are low
// [R2] keep chip select or gate high on every device not read
// [R3] device floats data when chip select high or gate high
// [R4] device data outputs are three-state, shareable
// [R5] erased bits read one; programming only clears bits
// [R6] programmed zeros are never electrically returned to one
// [R7] enter programming: supply on gate, raised core supply, select low
// [R8] present byte on data, pulse select after address and data stable
// [R9] device writes presented byte while select pulsed low
// [R10] each attempt is a 100 us pulse then a verify read
// [R11] repeat pulse and verify up to 10 times, then report failure
// [R12] device writes nothing and floats while select high under supply
// [R13] device outputs stored byte for verify with select and gate low
// [R14] after programming verify locations at normal supply and logic levels
// [R15] locations may be programmed in any order
// [R16] parallel devices respond identically to shared signals
// [R17] identifier mode: signature line at high voltage, select and gate low
// [R18] other address low; code select picks maker or device code
// [R19] drop supply before verify; never supply while device drives
`timescale 1ns/1ps
`include "epc_regs.vh"
module epc_ctrl #(
	parameter PULSE_CYC = `EPC_PULSE_CYC,
	parameter TRY_W     = 4
) (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// user command port
	input  wire        cmd_valid,
	input  wire [1:0]  cmd_op,
	input  wire [15:0] cmd_addr,
	input  wire [7:0]  cmd_wdata,
	output reg         cmd_ready,
	output reg         rsp_valid,
	output reg  [7:0]  rsp_rdata,
	output reg         rsp_fail,
	output reg  [3:0]  rsp_tries,
	// memory pins
	output reg  [15:0] address_lines,
	output reg         chip_sel_n,
	output reg         gate_n,
	output reg         vpp_on,
	output reg         vcc_prog_on,
	output reg         sig_hv_on,
	input  wire [7:0]  data_lines_in,
	output reg  [7:0]  data_lines_out,
	output reg         data_lines_oe_n
);
	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_RSET  = 8'h02;
	localparam [7:0] S_RWAIT = 8'h04;
	localparam [7:0] S_PSET  = 8'h08;
	localparam [7:0] S_PULSE = 8'h10;
	localparam [7:0] S_PDROP = 8'h20;
	localparam [7:0] S_VWAIT = 8'h40;
	localparam [7:0] S_DONE  = 8'h80;
	localparam [15:0] PULSE_LOAD = PULSE_CYC[15:0];
	localparam [15:0] SIG_BASE   = `EPC_SIG_ADDR;

	reg  [7:0]       state;
	reg  [1:0]       op;
	reg  [7:0]       wbyte;
	reg  [TRY_W-1:0] tries;
	reg  [7:0]       din_meta;
	reg  [7:0]       din_sync;
	reg              t_load;
	reg  [15:0]      t_count;
	wire             t_done;

	epc_timer #(.W(16)) u_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (t_load),
		.count   (t_count),
		.done    (t_done)
	);

	// data pins come from outside; two-stage synchroniser
	always @(posedge clk) begin
		if (sys_rst) begin
			din_meta <= `EPC_ERASED_BYTE;
			din_sync <= `EPC_ERASED_BYTE;
		end else begin
			din_meta <= data_lines_in;
			din_sync <= din_meta;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state           <= S_IDLE;
			op              <= `EPC_CMD_READ;
			wbyte           <= `EPC_ERASED_BYTE;
			tries           <= {TRY_W{1'b0}};
			cmd_ready       <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_rdata       <= 8'h00;
			rsp_fail        <= 1'b0;
			rsp_tries       <= 4'h0;
			address_lines   <= 16'h0000;
			chip_sel_n      <= 1'b1;
			gate_n          <= 1'b1;
			vpp_on          <= 1'b0;
			vcc_prog_on     <= 1'b0;
			sig_hv_on       <= 1'b0;
			data_lines_out  <= 8'h00;
			data_lines_oe_n <= 1'b1;
			t_load          <= 1'b0;
			t_count         <= 16'h0000;
		end else begin
			t_load    <= 1'b0;
			rsp_valid <= 1'b0;
			case (state)
			S_IDLE: begin
				// [R2] idle keeps the device deselected
				chip_sel_n <= 1'b1;
				gate_n     <= 1'b1;
				cmd_ready  <= 1'b1;
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					op        <= cmd_op;
					wbyte     <= cmd_wdata;
					tries     <= {TRY_W{1'b0}};
					t_load    <= 1'b1;
					// [R15] any address accepted, no sequence
					if (cmd_op == `EPC_CMD_PROG) begin
						// [R16] pins shared, no per-device state
						address_lines   <= cmd_addr;
						data_lines_out  <= cmd_wdata;
						data_lines_oe_n <= 1'b0;
						// [R7] supply on gate, raised core supply
						vcc_prog_on     <= 1'b1;
						vpp_on          <= 1'b1;
						t_count         <= `EPC_VPP_SETTLE_CYC;
						state           <= S_PSET;
					end else if (cmd_op == `EPC_CMD_SIG) begin
						// [R18] other address lines low, code select from bit 0
						address_lines <= {SIG_BASE[15:1], cmd_addr[0]};
						// [R17] signature line raised to high voltage
						sig_hv_on     <= 1'b1;
						t_count       <= `EPC_SETUP_CYC;
						state         <= S_RSET;
					end else begin
						address_lines <= cmd_addr;
						t_count       <= `EPC_SETUP_CYC;
						state         <= S_RSET;
					end
				end
			end
			S_RSET: begin
				if (t_done) begin
					// [R14] plain reads at logic levels with select and gate low; signature reads keep sig_hv_on high
					chip_sel_n <= 1'b0;
					gate_n     <= 1'b0;
					t_load     <= 1'b1;
					t_count    <= `EPC_ACCESS_CYC;
					state      <= S_RWAIT;
				end
			end
			S_RWAIT: begin
				if (t_done) begin
					rsp_rdata  <= din_sync;
					rsp_fail   <= 1'b0;
					rsp_tries  <= 4'h0;
					rsp_valid  <= 1'b1;
					chip_sel_n <= 1'b1;
					gate_n     <= 1'b1;
					sig_hv_on  <= 1'b0;
					state      <= S_DONE;
				end
			end
			S_PSET: begin
				if (t_done) begin
					// [R8] address and data stable; now pulse select
					chip_sel_n <= 1'b0;
					tries      <= tries + {{(TRY_W-1){1'b0}}, 1'b1};
					t_load     <= 1'b1;
					// [R10] one 100 us program pulse
					// timer load and state hop add cycles; trimmed so select is low PULSE_CYC cycles
					t_count    <= PULSE_LOAD - `EPC_TIMER_LAT;
					state      <= S_PULSE;
				end
			end
			S_PULSE: begin
				if (t_done) begin
					chip_sel_n      <= 1'b1;
					// [R19] supply removed and bus released before verify
					vpp_on          <= 1'b0;
					data_lines_oe_n <= 1'b1;
					t_load          <= 1'b1;
					t_count         <= `EPC_VPP_SETTLE_CYC;
					state           <= S_PDROP;
				end
			end
			S_PDROP: begin
				if (t_done) begin
					// [R13] verify read with select and gate low
					chip_sel_n <= 1'b0;
					gate_n     <= 1'b0;
					t_load     <= 1'b1;
					t_count    <= `EPC_ACCESS_CYC;
					state      <= S_VWAIT;
				end
			end
			S_VWAIT: begin
				if (t_done) begin
					chip_sel_n <= 1'b1;
					gate_n     <= 1'b1;
					t_load     <= 1'b1;
					// [R11] pass, or fail after tenth try, else retry
					if (din_sync == wbyte || tries == `EPC_MAX_TRIES) begin
						rsp_rdata   <= din_sync;
						rsp_fail    <= (din_sync != wbyte);
						rsp_tries   <= tries;
						rsp_valid   <= 1'b1;
						vcc_prog_on <= 1'b0;
						state       <= S_DONE;
					end else begin
						// [R19] gate back high in the same cycle supply is reapplied
						data_lines_oe_n <= 1'b0;
						vpp_on          <= 1'b1;
						t_count         <= `EPC_VPP_SETTLE_CYC;
						state           <= S_PSET;
					end
				end
			end
			S_DONE: begin
				cmd_ready <= 1'b1;
				state     <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// >>> design/epc_timer.v
// Purpose: down counter producing a one-cycle done pulse
// Assumes: load wins over counting
// Notes:   done pulses the cycle the count reaches zero
`timescale 1ns/1ps
module epc_timer #(
	parameter W = 16
) (
	// clock and reset
	input  wire         clk,
	input  wire         sys_rst,
	// control
	input  wire         load,
	input  wire [W-1:0] count,
	// status
	output reg          done
);
	reg [W-1:0] cnt;
	always @(posedge clk) begin
		if (sys_rst) begin
			cnt  <= {W{1'b0}};
			done <= 1'b0;
		end else if (load) begin
			cnt  <= count;
			done <= 1'b0;
		end else begin
			done <= (cnt == {{(W-1){1'b0}}, 1'b1});
			if (cnt != {W{1'b0}})
				cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> dv/epc_ctrl_checker.sv
// Purpose: pin-level checks for the programmer controller
// Assumes: one clock domain, sync reset
// Notes:   sees top ports only
`timescale 1ns/1ps
module epc_ctrl_checker #(
	parameter PULSE_CYC = 20
) (
	input wire        clk,
	input wire        sys_rst,
	input wire        cmd_ready,
	input wire        rsp_valid,
	input wire        rsp_fail,
	input wire [3:0]  rsp_tries,
	input wire [15:0] address_lines,
	input wire        chip_sel_n,
	input wire        gate_n,
	input wire        vpp_on,
	input wire        vcc_prog_on,
	input wire        sig_hv_on,
	input wire [7:0]  data_lines_out,
	input wire        data_lines_oe_n
);
	reg [31:0] pcnt;
	always @(posedge clk) begin
		if (sys_rst || chip_sel_n || !vpp_on)
			pcnt <= 32'h0;
		else
			pcnt <= pcnt + 32'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_pulse_start;
		$fell(chip_sel_n) && vpp_on;
	endsequence
	sequence s_pulse_end;
		$rose(chip_sel_n) && $past(vpp_on);
	endsequence
	AST_GATE_VPP: assert property (vpp_on |-> gate_n) else $error("gate low under supply");
	AST_OE_GATE: assert property (!gate_n |-> data_lines_oe_n) else $error("bus driven in read");
	AST_PROG_SETUP: assert property (s_pulse_start |-> $stable(address_lines) && $stable(data_lines_out)
		&& !data_lines_oe_n) else $error("pulse before stable");
	AST_PROG_HOLD: assert property (vpp_on && !chip_sel_n && $past(!chip_sel_n) |-> $stable(address_lines)
		&& $stable(data_lines_out)) else $error("change in pulse");
	AST_PULSE_LEN: assert property (s_pulse_end |-> pcnt == PULSE_CYC) else $error("pulse length");
	AST_TRIES: assert property (rsp_valid |-> rsp_tries <= 4'ha && (!rsp_fail || rsp_tries == 4'ha))
		else $error("try count");
	AST_SIG: assert property (sig_hv_on |-> address_lines[15:1] == 15'h0 && !vpp_on)
		else $error("signature address");
	AST_IDLE: assert property (cmd_ready |-> chip_sel_n && !vpp_on && !sig_hv_on)
		else $error("idle not deselected");
	AST_VCC_PROG: assert property (vpp_on |-> vcc_prog_on) else $error("supply without core raise");
endmodule

// >>> dv/epc_ctrl_tb.sv
// Purpose: self-checking bench for the programmer controller
// Assumes: short pulse parameter
// Notes:   memory model on the pins
`timescale 1ns/1ps
module epc_ctrl_tb;
	reg         clk, sys_rst, cmd_valid;
	reg  [1:0]  cmd_op;
	reg  [15:0] cmd_addr;
	reg  [7:0]  cmd_wdata;
	wire        cmd_ready, rsp_valid, rsp_fail, chip_sel_n, gate_n, vpp_on, vcc_prog_on, sig_hv_on, data_lines_oe_n;
	wire [7:0]  rsp_rdata, data_lines_in, data_lines_out;
	wire [3:0]  rsp_tries;
	wire [15:0] address_lines;
	integer     n_fail, total_checks;
	epc_ctrl #(.PULSE_CYC(20)) u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_fail(rsp_fail), .rsp_tries(rsp_tries), .address_lines(address_lines),
		.chip_sel_n(chip_sel_n), .gate_n(gate_n), .vpp_on(vpp_on), .vcc_prog_on(vcc_prog_on),
		.sig_hv_on(sig_hv_on), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n));
	epc_mem_model u_mem (.clk(clk), .address_lines(address_lines), .chip_sel_n(chip_sel_n), .gate_n(gate_n),
		.vpp_on(vpp_on), .sig_hv_on(sig_hv_on), .data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in));
	always #2.5 clk = ~clk;
	task end_sim;
		begin
			if (n_fail == 0 && total_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [7:0] exp, input [7:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task run(input [1:0] op, input [15:0] addr, input [7:0] wd);
		integer k;
		begin
			k = 0;
			@(posedge clk);
			cmd_op <= op;
			cmd_addr <= addr;
			cmd_wdata <= wd;
			cmd_valid <= 1'b1;
			do @(posedge clk); while (cmd_ready !== 1'b1);
			cmd_valid <= 1'b0;
			while (rsp_valid !== 1'b1 && k < 3000) begin
				@(posedge clk);
				k = k + 1;
			end
			chk("response", 8'h01, {7'h0, rsp_valid});
		end
	endtask
	task t_read_erased;
		begin
			run(2'h0, 16'h8001, 8'h00);
			chk("erased", 8'hff, rsp_rdata);
			run(2'h3, 16'h0002, 8'h00);
			chk("read3", 8'hff, rsp_rdata);
		end
	endtask
	task t_prog_order;
		begin
			run(2'h1, 16'hffff, 8'ha5);
			chk("tries", 8'h01, {4'h0, rsp_tries});
			run(2'h1, 16'h0000, 8'h3c);
			chk("fail", 8'h00, {7'h0, rsp_fail});
			run(2'h0, 16'hffff, 8'h00);
			chk("readback", 8'ha5, rsp_rdata);
		end
	endtask
	task t_no_erase;
		begin
			run(2'h1, 16'hffff, 8'hff);
			chk("fail", 8'h01, {7'h0, rsp_fail});
			chk("tries", 8'h0a, {4'h0, rsp_tries});
			chk("kept", 8'ha5, rsp_rdata);
		end
	endtask
	task t_slow;
		begin
			run(2'h1, 16'h0100, 8'h0f);
			chk("tries", 8'h03, {4'h0, rsp_tries});
			chk("fail", 8'h00, {7'h0, rsp_fail});
		end
	endtask
	task t_sig;
		begin
			run(2'h2, 16'h0000, 8'h00);
			chk("mfg", 8'h3c, rsp_rdata);
			run(2'h2, 16'h0001, 8'h00);
			chk("dev", 8'h5a, rsp_rdata);
		end
	endtask
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_addr = 16'h0;
		cmd_wdata = 8'h0;
		n_fail = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_read_erased;
		t_prog_order;
		t_no_erase;
		t_slow;
		t_sig;
		end_sim;
	end
	initial begin
		#100000;
		n_fail = n_fail + 1;
		end_sim;
	end
endmodule
bind epc_ctrl epc_ctrl_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .rsp_tries(rsp_tries),
	.address_lines(address_lines), .chip_sel_n(chip_sel_n), .gate_n(gate_n), .vpp_on(vpp_on),
	.vcc_prog_on(vcc_prog_on), .sig_hv_on(sig_hv_on), .data_lines_out(data_lines_out),
	.data_lines_oe_n(data_lines_oe_n));

// >>> dv/epc_mem_model.sv
// Purpose: behavioural model of the 64K x 8 memory
// Assumes: controller resolves nothing; bus resolved here
// Notes:   one slow cell needs three pulses
`timescale 1ns/1ps
module epc_mem_model #(
	parameter [7:0]  MFG_CODE  = 8'h3c, // arbitrary value
	parameter [7:0]  DEV_CODE  = 8'h5a, // arbitrary value
	parameter [15:0] SLOW_ADDR = 16'h0100
) (
	input  wire        clk,
	input  wire [15:0] address_lines,
	input  wire        chip_sel_n,
	input  wire        gate_n,
	input  wire        vpp_on,
	input  wire        sig_hv_on,
	input  wire [7:0]  data_lines_out,
	input  wire        data_lines_oe_n,
	output wire [7:0]  data_lines_in
);
	reg [7:0] mem [0:65535];
	reg [7:0] last;
	reg [3:0] slow_n;
	integer   i;
	wire      rd_en = !chip_sel_n && !gate_n && !vpp_on;
	wire [7:0] rd_q = sig_hv_on ? (address_lines[0] ? DEV_CODE : MFG_CODE) : mem[address_lines];
	initial begin
		for (i = 0; i < 65536; i = i + 1)
			mem[i] = 8'hff;
		slow_n = 4'h0;
		last = 8'h00;
	end
	always @(negedge chip_sel_n) begin
		if (vpp_on && address_lines == SLOW_ADDR)
			slow_n = slow_n + 4'h1;
		if (vpp_on && (address_lines != SLOW_ADDR || slow_n > 4'h2))
			mem[address_lines] = mem[address_lines] & data_lines_out;
	end
	assign data_lines_in = !data_lines_oe_n ? data_lines_out : rd_en ? rd_q : ~last;
	always @(posedge clk)
		last <= data_lines_in;
endmodule

// >>> include/epc_regs.vh
// Purpose: constants for the memory programmer controller
// Assumes: 200 MHz clock
// Notes:   pulse time in microseconds, its cycle count derived; other times given in cycles
`ifndef EPC_REGS_VH
`define EPC_REGS_VH
`define EPC_CLK_MHZ        200
`define EPC_PULSE_US       100
`define EPC_PULSE_CYC      (`EPC_PULSE_US * `EPC_CLK_MHZ)
`define EPC_MAX_TRIES      4'ha
`define EPC_SETUP_CYC      16'h0004
`define EPC_ACCESS_CYC     16'h0028
`define EPC_VPP_SETTLE_CYC 16'h0028
`define EPC_TIMER_LAT      16'h0002
`define EPC_ERASED_BYTE    8'hff
`define EPC_SIG_ADDR       16'h0000
`define EPC_CMD_READ       2'h0
`define EPC_CMD_PROG       2'h1
`define EPC_CMD_SIG        2'h2
`endif
